// ---- common/irb_pkg.sv ----
package irb_pkg;

    // clock and slot timing
    localparam int CLK_HZ            = 100_000_000;
    localparam int SLOT_MS           = 10;
    localparam int SLOT_CYCLES       = CLK_HZ / 1000 * SLOT_MS;
    // classification thresholds in percent of a slot
    localparam int ZERO_ONE_PCT      = 35;
    localparam int ONE_POS_PCT       = 65;
    localparam int MIN_MARK_PCT      = 5;
    localparam int ZERO_ONE_CYCLES   = SLOT_CYCLES / 100 * ZERO_ONE_PCT;
    localparam int ONE_POS_CYCLES    = SLOT_CYCLES / 100 * ONE_POS_PCT;
    localparam int MIN_MARK_CYCLES   = SLOT_CYCLES / 100 * MIN_MARK_PCT;
    localparam int SLOTS_PER_FRAME   = 100;
    localparam int CENTURY_BASE      = 2000;

    // slot positions of the fields
    localparam int SEC_UNITS_SLOT    = 1;
    localparam int SEC_TENS_SLOT     = 6;
    localparam int MIN_UNITS_SLOT    = 10;
    localparam int MIN_TENS_SLOT     = 15;
    localparam int HR_UNITS_SLOT     = 20;
    localparam int HR_TENS_SLOT      = 25;
    localparam int DAY_UNITS_SLOT    = 30;
    localparam int DAY_TENS_SLOT     = 35;
    localparam int DAY_HUND_SLOT     = 40;
    localparam int YR_UNITS_SLOT     = 50;
    localparam int YR_TENS_SLOT      = 55;

    // option code digits accepted per input mode
    localparam logic [3:0] OPT_MOD_PULSE = 4'h0;
    localparam logic [3:0] OPT_MOD_AM    = 4'h1;
    localparam logic [3:0] OPT_CAR_DC    = 4'h0;
    localparam logic [3:0] OPT_CAR_1K    = 4'h2;
    localparam logic [3:0] OPT_CONTENT_MAX = 4'h7;

    typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_POS, SYM_BAD} irb_sym_t;

    // decoded time of year, BCD digits
    typedef struct packed {
        logic [3:0] year_tens;
        logic [3:0] year_units;
        logic [1:0] day_hund;
        logic [3:0] day_tens;
        logic [3:0] day_units;
        logic [1:0] hour_tens;
        logic [3:0] hour_units;
        logic [2:0] min_tens;
        logic [3:0] min_units;
        logic [2:0] sec_tens;
        logic [3:0] sec_units;
    } irb_toy_t;

    // one classified symbol
    typedef struct packed {
        logic     valid;
        irb_sym_t sym;
    } irb_symbol_t;

endpackage

// ---- dv/irb_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module irb_src_model
    import irb_pkg::*;
#(
    parameter int SLOT_CYC = SLOT_CYCLES // slot length in cycles
)
(
    input  wire logic SYS_CLK_I, // system clock
    output logic      LINE_O     // dc level code line
);
    // line rests at space between marks
    initial LINE_O = 1'b0;
    // one slot: mark held high, then space held low, widths in cycles
    task automatic send_width(input int mark, input int space);
        @(negedge SYS_CLK_I);
        LINE_O = 1'b1;
        repeat (mark) @(negedge SYS_CLK_I);
        LINE_O = 1'b0;
        repeat (space) @(negedge SYS_CLK_I);
    endtask
    // one whole slot of a nominal symbol, slot length kept exact
    task automatic send_sym(input irb_sym_t s);
        int mark;
        mark = (s == SYM_POS) ? SLOT_CYC / 5 * 4 : (s == SYM_ONE) ? SLOT_CYC / 2 : SLOT_CYC / 5;
        send_width(mark, SLOT_CYC - mark - 1);
    endtask
    // one frame: identifiers at slot 0 and slots ending in 9, one slot may drop its identifier
    task automatic send_frame(input logic [99:0] bits, input int drop);
        for (int s = 0; s < SLOTS_PER_FRAME; s++)
        begin
            if ((s == 0 || s % 10 == 9) && s != drop)
                send_sym(SYM_POS);
            else
                send_sym(bits[s] ? SYM_ONE : SYM_ZERO);
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/irb_timecode_decoder_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module irb_timecode_decoder_chk
    import irb_pkg::*;
(
    input wire logic        SYS_CLK_I,    // clock
    input wire logic        RESET_N_I,    // reset, low
    input wire logic        LINE_I,       // code line
    input wire logic        AM_MODE_I,    // am mode
    input wire logic [11:0] OPTION_I,     // option code
    input wire logic [13:0] HOST_YEAR_I,  // host year
    input wire logic        OPTION_OK_O,  // option accepted
    input wire logic        BOUNDARY_O,   // boundary pulse
    input wire logic        TIME_VALID_O, // time valid
    input wire logic        FRAME_ERR_O,  // frame error
    input wire irb_toy_t    TOY_O,        // decoded time
    input wire logic [13:0] YEAR_O        // full year
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    logic       opt_acc;
    logic [7:0] yr;
    // accepted option family per mode, and received year digits
    assign opt_acc = (OPTION_I[3:0] <= 4'h7) && (OPTION_I[11:4] == (AM_MODE_I ? 8'h12 : 8'h00));
    assign yr = {TOY_O.year_tens, TOY_O.year_units};
    // boundary is a single pulse led by a fresh mark
    sequence s_pulse;
        BOUNDARY_O ##1 !BOUNDARY_O;
    endsequence
    sequence s_lead;
        $past(LINE_I, 2) && !$past(LINE_I, 4);
    endsequence
    a_option_match: assert property (OPTION_OK_O == opt_acc)
        else $error("option acceptance wrong");
    a_option_content: assert property (OPTION_I[3:0] > 4'h7 |-> !OPTION_OK_O)
        else $error("content digit above 7 accepted");
    a_boundary_pulse: assert property ($rose(BOUNDARY_O) |-> s_pulse)
        else $error("boundary pulse too long");
    a_boundary_lead: assert property (BOUNDARY_O |-> s_lead)
        else $error("boundary not at mark leading edge");
    a_boundary_loads: assert property (BOUNDARY_O |-> TIME_VALID_O && !FRAME_ERR_O)
        else $error("boundary without clean load");
    a_toy_hold: assert property (!$stable(TOY_O) |-> BOUNDARY_O || !TIME_VALID_O)
        else $error("time changed off boundary");
    a_year_century: assert property (BOUNDARY_O && yr != 8'h00 |->
        YEAR_O == 14'd2000 + 14'(TOY_O.year_tens) * 14'd10 + 14'(TOY_O.year_units))
        else $error("year not in century");
    a_year_host: assert property (BOUNDARY_O && yr == 8'h00 |-> YEAR_O == $past(HOST_YEAR_I))
        else $error("host year not used");
endmodule
bind irb_timecode_decoder irb_timecode_decoder_chk i_chk (
    .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .LINE_I(LINE_I), .AM_MODE_I(AM_MODE_I),
    .OPTION_I(OPTION_I), .HOST_YEAR_I(HOST_YEAR_I), .OPTION_OK_O(OPTION_OK_O),
    .BOUNDARY_O(BOUNDARY_O), .TIME_VALID_O(TIME_VALID_O), .FRAME_ERR_O(FRAME_ERR_O),
    .TOY_O(TOY_O), .YEAR_O(YEAR_O));
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
    import irb_pkg::*;
;
    logic        sys_clk, reset_n, line, am_mode, option_ok;
    logic        boundary, time_valid, frame_err, start;
    logic [11:0] option;
    logic [13:0] host_year, year;
    irb_toy_t    time_of_year_field;
    irb_symbol_t symbol;
    int          errors, checks, starts, bounds;
    irb_sym_t    sym_q[$];
    int          sec, mnt, hr, day, yv;
    irb_toy_t    tv, prev_toy, bnd_toy;
    logic [13:0] prev_year, bnd_year;
    logic [99:0] frm;
    logic [11:0] corner[8] = '{12'h000, 12'h007, 12'h008, 12'h120,
                               12'h127, 12'h128, 12'h100, 12'h020};
    // short slot keeps one frame at 10,000 cycles; thresholds scale with it
    localparam int SLOT = 100;
    localparam int ZO   = SLOT / 100 * ZERO_ONE_PCT;
    localparam int OP   = SLOT / 100 * ONE_POS_PCT;
    localparam int MN   = SLOT / 100 * MIN_MARK_PCT;
    // sync pair, nominal widths, threshold corners, short mark last
    int          widths[9] = '{OP + 2, SLOT / 5 * 4, SLOT / 5,
                               SLOT / 2, ZO - 2, ZO + 2,
                               OP - 2, MN + 2, MN - 2};
    // 100 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    irb_src_model #(.SLOT_CYC(SLOT)) i_irb_src_model (.SYS_CLK_I(sys_clk), .LINE_O(line));
    irb_timecode_decoder #(.SLOT_CYC(SLOT)) i_irb_timecode_decoder (
        .SYS_CLK_I(sys_clk), .RESET_N_I(reset_n), .LINE_I(line), .AM_MODE_I(am_mode),
        .OPTION_I(option), .HOST_YEAR_I(host_year), .OPTION_OK_O(option_ok),
        .BOUNDARY_O(boundary), .TIME_VALID_O(time_valid), .FRAME_ERR_O(frame_err),
        .TOY_O(time_of_year_field), .YEAR_O(year));
    // classifier results observed inside the design's top
    assign start  = i_irb_timecode_decoder.start;
    assign symbol = i_irb_timecode_decoder.symbol;
    // collect start pulses, boundaries with their loaded time, and classified symbols
    always @(posedge sys_clk)
    begin
        if (start === 1'b1) starts++;
        if (boundary === 1'b1)
        begin
            bounds++;
            bnd_toy  = time_of_year_field;
            bnd_year = year;
        end
        if (symbol.valid === 1'b1) sym_q.push_back(symbol.sym);
    end
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_sym(input irb_sym_t got, input irb_sym_t exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [41:0] got, input logic [41:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bcd digits of a time of year
    function automatic irb_toy_t exp_toy(input int s, input int m, input int h, input int d,
                                         input int y);
        irb_toy_t t;
        t.year_tens  = 4'(y / 10);
        t.year_units = 4'(y % 10);
        t.day_hund   = 2'(d / 100);
        t.day_tens   = 4'(d / 10 % 10);
        t.day_units  = 4'(d % 10);
        t.hour_tens  = 2'(h / 10);
        t.hour_units = 4'(h % 10);
        t.min_tens   = 3'(m / 10);
        t.min_units  = 4'(m % 10);
        t.sec_tens   = 3'(s / 10);
        t.sec_units  = 4'(s % 10);
        return t;
    endfunction
    // frame bits, lsb first per digit, with control bits and binary seconds as filler
    function automatic logic [99:0] mk_frame(input irb_toy_t t, input logic [17:0] cb,
                                             input logic [16:0] seconds_of_day);
        logic [99:0] f;
        f = '0;
        f[SEC_UNITS_SLOT +: 4] = t.sec_units;
        f[SEC_TENS_SLOT +: 3]  = t.sec_tens;
        f[MIN_UNITS_SLOT +: 4] = t.min_units;
        f[MIN_TENS_SLOT +: 3]  = t.min_tens;
        f[HR_UNITS_SLOT +: 4]  = t.hour_units;
        f[HR_TENS_SLOT +: 2]   = t.hour_tens;
        f[DAY_UNITS_SLOT +: 4] = t.day_units;
        f[DAY_TENS_SLOT +: 4]  = t.day_tens;
        f[DAY_HUND_SLOT +: 2]  = t.day_hund;
        f[YR_UNITS_SLOT +: 4]  = t.year_units;
        f[YR_TENS_SLOT +: 4]   = t.year_tens;
        f[68:60] = cb[8:0];
        f[78:70] = cb[17:9];
        f[88:80] = seconds_of_day[8:0];
        f[97:90] = seconds_of_day[16:9];
        return f;
    endfunction
    task automatic cmp_cnt(input int got, input int exp);
        checks++;
        if (got != exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // accepted option family per mode
    function automatic logic exp_ok(input logic am, input logic [11:0] opt);
        return (opt[3:0] <= 4'h7) && (opt[11:4] == (am ? 8'h12 : 8'h00));
    endfunction
    // symbol expected from a mark width
    function automatic irb_sym_t exp_sym(input int w);
        if (w < MN) return SYM_BAD;
        if (w < ZO) return SYM_ZERO;
        if (w < OP) return SYM_ONE;
        return SYM_POS;
    endfunction
    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        reset_n = 1'b0;
        am_mode = 1'b0;
        option = 12'h000;
        host_year = 14'h0000;
        void'($urandom(32'h0337));
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        host_year = 14'($urandom_range(2000, 2099));
        @(negedge sys_clk);
        cmp_bit(|{boundary, time_valid, frame_err, time_of_year_field, year}, 1'b0);
        // option codes: corners in both modes, then random digits
        for (int i = 0; i < 80; i++)
        begin
            @(negedge sys_clk);
            am_mode = i[0];
            option = (i < 16) ? corner[i >> 1] : {4'($urandom_range(0, 2)),
                     4'($urandom_range(0, 5)), 4'($urandom_range(0, 15))};
            #1 cmp_bit(option_ok, exp_ok(am_mode, option));
        end
        // symbol stream with random space lengths
        foreach (widths[k])
        begin
            i_irb_src_model.send_width(widths[k], 16 + $urandom_range(0, 31));
            cmp_cnt(sym_q.size(), 1);
            if (sym_q.size() > 0) cmp_sym(sym_q.pop_front(), exp_sym(widths[k]));
        end
        cmp_cnt(starts, 9);
        cmp_bit(frame_err, 1'b1);
        cmp_bit(time_valid, 1'b0);
        cmp_cnt(bounds, 0);
        // frames: lock, clean year, year 00, then one missing identifier at slot 49
        for (int k = 0; k < 4; k++)
        begin
            sec = $urandom_range(0, 59);
            mnt = $urandom_range(0, 59);
            hr  = $urandom_range(0, 23);
            day = $urandom_range(1, 366);
            yv  = (k == 2) ? 0 : $urandom_range(1, 99);
            tv  = exp_toy(sec, mnt, hr, day, yv);
            frm = mk_frame(tv, 18'($urandom), 17'(hr * 3600 + mnt * 60 + sec));
            i_irb_src_model.send_frame(frm, (k == 3) ? 49 : 100);
            if (k >= 2)
            begin
                cmp_cnt(bounds, k - 1);
                cmp_word(42'(bnd_toy), 42'(prev_toy));
                cmp_word(42'(bnd_year), 42'(prev_year));
                cmp_bit(time_valid, k == 2);
                cmp_bit(frame_err, k == 3);
            end
            prev_toy  = tv;
            prev_year = (yv == 0) ? host_year : 14'(CENTURY_BASE + yv);
        end
        // reference marker after an errored frame gives no boundary
        i_irb_src_model.send_width(SLOT / 5 * 4, 40);
        cmp_cnt(bounds, 2);
        // second reset clears the error
        @(negedge sys_clk);
        reset_n = 1'b0;
        @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        cmp_bit(|{frame_err, time_valid, boundary, time_of_year_field, year}, 1'b0);
        final_report;
    end
    // watchdog at about two and a half times the expected run of 41,000 cycles
    initial
    begin
        #1_000_000;
        errors++;
        final_report;
    end
endmodule
`default_nettype wire

// ---- rtl/irb_symbol_classifier.sv ----
`timescale 1ns/1ps
`default_nettype none
module irb_symbol_classifier
    import irb_pkg::*;
#(
    parameter int SLOT_CYC = SLOT_CYCLES   // slot length in clock cycles
)
(
    input  wire logic        SYS_CLK_I,   // system clock
    input  wire logic        RESET_N_I,   // async reset, low
    input  wire logic        LINE_I,      // dc level code input
    output logic             START_O,     // pulse at mark leading edge
    output irb_symbol_t      SYMBOL_O     // classified symbol at mark end
);

    // thresholds follow the slot length so a short slot scales them all
    localparam int CW      = $clog2(SLOT_CYC + 1);
    localparam int ZO_CYC  = SLOT_CYC / 100 * ZERO_ONE_PCT;
    localparam int OP_CYC  = SLOT_CYC / 100 * ONE_POS_PCT;
    localparam int MIN_CYC = SLOT_CYC / 100 * MIN_MARK_PCT;

    logic          line_reg;
    logic          line_next;
    logic [CW-1:0] width_reg;
    logic [CW-1:0] width_next;
    irb_symbol_t   symbol_reg;
    irb_symbol_t   symbol_next;
    logic          start_reg;
    logic          start_next;

    // measure the high time and classify it at the falling edge
    always_comb
    begin
        line_next        = LINE_I;
        width_next       = width_reg;
        symbol_next      = '0;
        start_next       = 1'b0;
        if (LINE_I && !line_reg)                          // mark leading edge, line was low
        begin
            width_next = CW'(1);
            start_next = 1'b1;
        end
        else if (LINE_I && width_reg < CW'(SLOT_CYC))
            width_next = width_reg + CW'(1);
        if (!LINE_I && line_reg)
        begin
            symbol_next.valid = 1'b1;
            if (width_reg < CW'(MIN_CYC) || width_reg >= CW'(SLOT_CYC))
                symbol_next.sym = SYM_BAD;
            else if (width_reg < CW'(ZO_CYC))
                symbol_next.sym = SYM_ZERO;
            else if (width_reg < CW'(OP_CYC))
                symbol_next.sym = SYM_ONE;
            else
                symbol_next.sym = SYM_POS;
        end
    end

    // register stage
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            line_reg   <= 1'b0;
            width_reg  <= '0;
            symbol_reg <= '0;
            start_reg  <= 1'b0;
        end
        else
        begin
            line_reg   <= line_next;
            width_reg  <= width_next;
            symbol_reg <= symbol_next;
            start_reg  <= start_next;
        end
    end

    assign SYMBOL_O = symbol_reg;
    assign START_O  = start_reg;

endmodule
`default_nettype wire

// ---- rtl/irb_timecode_decoder.sv ----
// Contract
// - mark width: 20% zero, 50% one, 80% position identifier
// - second boundary is leading edge of second of two back-to-back identifiers
// - dc variant: mark is logic high, space is logic low
// - slots are 10 ms, one frame of 100 slots per second
// - slot 0 is reference marker; identifiers at slots 9,19..99
// - seconds 1-4/6-8, minutes 10-13/15-17, hours 20-23/25-26
// - day of year units 30-33, tens 35-38, hundreds 40-41
// - year units 50-53, tens 55-58, or control function bits
// - binary seconds of day slots 80-88, lsb first
// - binary seconds of day upper bits slots 90-97
// - timebase loads from bcd time fields; control and binary seconds ignored
// - received year 00 means use host supplied year
// - years 01-99 are 2001-2099
// - option code: modulation, carrier, content digits
// - dc mode accepts 00X, am mode accepts 12X
`timescale 1ns/1ps
`default_nettype none
module irb_timecode_decoder
    import irb_pkg::*;
#(
    parameter int SLOT_CYC = SLOT_CYCLES       // slot length in clock cycles
)
(
    input  wire logic        SYS_CLK_I,       // system clock, 100 MHz
    input  wire logic        RESET_N_I,       // async reset, low
    input  wire logic        LINE_I,          // dc level timecode input
    input  wire logic        AM_MODE_I,       // input configured as am (demodulated)
    input  wire logic [11:0] OPTION_I,        // option code digits, hex per digit
    input  wire logic [13:0] HOST_YEAR_I,     // host year, full binary
    output logic             OPTION_OK_O,     // option code accepted
    output logic             BOUNDARY_O,      // pulse at second boundary
    output logic             TIME_VALID_O,    // time loaded from a clean frame
    output logic             FRAME_ERR_O,     // last frame had a bad symbol or identifier
    output irb_toy_t         TOY_O,           // time_of_year_field, bcd
    output logic [13:0]      YEAR_O           // resolved full year
);

    irb_symbol_t symbol;
    logic        start;

    irb_symbol_classifier #(.SLOT_CYC(SLOT_CYC)) u_class (
        .SYS_CLK_I (SYS_CLK_I),
        .RESET_N_I (RESET_N_I),
        .LINE_I    (LINE_I),
        .START_O   (start),
        .SYMBOL_O  (symbol)
    );

    typedef enum logic [1:0] {ST_HUNT, ST_PAIR, ST_FRAME} irb_state_t;

    irb_state_t  state_reg,   state_next;
    logic [6:0]  slot_reg,    slot_next;
    logic [99:0] bits_reg,    bits_next;
    logic        err_reg,     err_next;
    logic        have_reg,    have_next;
    logic        pend_reg,    pend_next;
    logic        bnd_reg,     bnd_next;
    logic        valid_reg,   valid_next;
    logic        ferr_reg,    ferr_next;
    irb_toy_t    toy_reg,     toy_next;
    logic [13:0] year_reg,    year_next;
    logic        opt_ok;
    logic        is_pos;
    logic        pos_expected;
    irb_toy_t    asm_toy;
    logic [6:0]  yr_bin;

    // option family check per input mode
    always_comb
    begin
        if (AM_MODE_I)
            opt_ok = OPTION_I[11:8] == OPT_MOD_AM && OPTION_I[7:4] == OPT_CAR_1K;
        else
            opt_ok = OPTION_I[11:8] == OPT_MOD_PULSE && OPTION_I[7:4] == OPT_CAR_DC;
        opt_ok = opt_ok && OPTION_I[3:0] <= OPT_CONTENT_MAX;
    end

    // identifier expected at slot 0 and every slot ending in 9
    assign is_pos       = symbol.valid && symbol.sym == SYM_POS;
    assign pos_expected = (slot_reg == 7'd0) || (slot_reg % 7'd10 == 7'd9);

    // assemble bcd digits, lsb first; binary seconds and control bits unused
    always_comb
    begin
        asm_toy            = '0;
        for (int i = 0; i < 4; i++)
        begin
            asm_toy.sec_units[i]  = bits_reg[SEC_UNITS_SLOT + i];
            asm_toy.min_units[i]  = bits_reg[MIN_UNITS_SLOT + i];
            asm_toy.hour_units[i] = bits_reg[HR_UNITS_SLOT + i];
            asm_toy.day_units[i]  = bits_reg[DAY_UNITS_SLOT + i];
            asm_toy.day_tens[i]   = bits_reg[DAY_TENS_SLOT + i];
            asm_toy.year_units[i] = bits_reg[YR_UNITS_SLOT + i];
            asm_toy.year_tens[i]  = bits_reg[YR_TENS_SLOT + i];
            if (i < 3)
            begin
                asm_toy.sec_tens[i] = bits_reg[SEC_TENS_SLOT + i];
                asm_toy.min_tens[i] = bits_reg[MIN_TENS_SLOT + i];
            end
            if (i < 2)
            begin
                asm_toy.hour_tens[i] = bits_reg[HR_TENS_SLOT + i];
                asm_toy.day_hund[i]  = bits_reg[DAY_HUND_SLOT + i];
            end
        end
        yr_bin = 7'(asm_toy.year_tens) * 7'd10 + 7'(asm_toy.year_units);
    end

    // frame tracking, slot counting and timebase load
    always_comb
    begin
        state_next = state_reg;
        slot_next  = slot_reg;
        bits_next  = bits_reg;
        err_next   = err_reg;
        have_next  = have_reg;
        pend_next  = pend_reg;
        bnd_next   = 1'b0;
        valid_next = valid_reg;
        ferr_next  = ferr_reg;
        toy_next   = toy_reg;
        year_next  = year_reg;
        // boundary instant is the leading edge of the reference marker
        if (start && pend_reg)
        begin
            bnd_next  = 1'b1;
            pend_next = 1'b0;
            if (have_reg)
            begin
                toy_next   = asm_toy;
                valid_next = 1'b1;
                if (yr_bin == 7'd0)
                    year_next = HOST_YEAR_I;
                else
                    year_next = 14'(CENTURY_BASE) + 14'(yr_bin);
                have_next = 1'b0;
            end
        end
        if (symbol.valid)
        begin
            unique case (state_reg)
                ST_HUNT:
                    if (is_pos)
                        state_next = ST_PAIR;
                ST_PAIR:
                    if (is_pos)
                    begin
                        state_next = ST_FRAME;
                        slot_next  = 7'd1;
                        err_next   = 1'b0;
                    end
                    else
                        state_next = ST_HUNT;
                ST_FRAME:
                begin
                    // binary seconds slots are stored but never read
                    bits_next[slot_reg] = symbol.sym == SYM_ONE;
                    if (symbol.sym == SYM_BAD || (is_pos != pos_expected))
                        err_next = 1'b1;
                    if (slot_reg == 7'(SLOTS_PER_FRAME - 1))
                    begin
                        // next slot opens a new frame; its marker edge is the boundary only if this frame was clean
                        have_next  = !(err_reg || symbol.sym == SYM_BAD || !is_pos);
                        ferr_next  = err_reg || !is_pos || symbol.sym == SYM_BAD;
                        if (have_next)
                            pend_next = 1'b1;
                        else
                            valid_next = 1'b0;
                        slot_next  = 7'd0;
                        state_next = is_pos ? ST_PAIR : ST_HUNT;
                    end
                    else if (symbol.sym == SYM_BAD)
                    begin
                        ferr_next  = 1'b1;
                        valid_next = 1'b0;
                        state_next = ST_HUNT;
                    end
                    else
                        slot_next = slot_reg + 7'd1;
                end
                default:
                    state_next = ST_HUNT;
            endcase
        end
    end

    // register stage
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            state_reg <= ST_HUNT;
            slot_reg  <= '0;
            bits_reg  <= '0;
            err_reg   <= 1'b0;
            have_reg  <= 1'b0;
            pend_reg  <= 1'b0;
            bnd_reg   <= 1'b0;
            valid_reg <= 1'b0;
            ferr_reg  <= 1'b0;
            toy_reg   <= '0;
            year_reg  <= '0;
        end
        else
        begin
            state_reg <= state_next;
            slot_reg  <= slot_next;
            bits_reg  <= bits_next;
            err_reg   <= err_next;
            have_reg  <= have_next;
            pend_reg  <= pend_next;
            bnd_reg   <= bnd_next;
            valid_reg <= valid_next;
            ferr_reg  <= ferr_next;
            toy_reg   <= toy_next;
            year_reg  <= year_next;
        end
    end

    assign OPTION_OK_O  = opt_ok;
    assign BOUNDARY_O   = bnd_reg;
    assign TIME_VALID_O = valid_reg;
    assign FRAME_ERR_O  = ferr_reg;
    assign TOY_O        = toy_reg;
    assign YEAR_O       = year_reg;

endmodule
`default_nettype wire
